// File: rtl/vsp_consts.svh
// constants of the video memory serial port controller: offsets, fields, timing
// assumes a 125 MHz pclk and the sequencing in vsp_ctrl
//
// Function
// - controller zeroes every mask bit on write
// - controller: set jumps, single, then splits; only single before splits is enforced, jumps are accepted at any time
// - controller: single transfer before serial clocks
// - controller: wait 100 us, eight dummies
// - controller: column strobe low every write transfer
`ifndef VSP_CONSTS_SVH
`define VSP_CONSTS_SVH

// ------------------------------------------------
// register offsets
// ------------------------------------------------
`define VSP_OFF_CTRL 8'h00
`define VSP_OFF_ADDR 8'h04
`define VSP_OFF_SER 8'h08
`define VSP_OFF_STAT 8'h0c

// ------------------------------------------------
// field positions
// ------------------------------------------------
`define VSP_CTRL_GO 0
`define VSP_CTRL_CMD_LO 1
`define VSP_CTRL_CMD_HI 3
`define VSP_ADDR_ROW_LO 0
`define VSP_ADDR_ROW_HI 8
`define VSP_ADDR_COL_LO 16
`define VSP_ADDR_COL_HI 24
`define VSP_SER_GATE 16
`define VSP_STAT_HALF 0
`define VSP_STAT_BUSY 1
`define VSP_STAT_PWR_OK 2
`define VSP_STAT_READY 3
`define VSP_STAT_MODE_RD 4
`define VSP_STAT_REFUSED 5

// ------------------------------------------------
// timing
// ------------------------------------------------
`define VSP_CLK_NS 8
`define VSP_T_STB_NS 40
`define VSP_T_SC_NS 24
`define VSP_T_PWR_US 100
`define VSP_DUMMY_N 8
`define VSP_CYC_UP(ns) ((((ns) + `VSP_CLK_NS - 1) / `VSP_CLK_NS))
`define VSP_STB_CYC `VSP_CYC_UP(`VSP_T_STB_NS)
`define VSP_SC_CYC `VSP_CYC_UP(`VSP_T_SC_NS)
`define VSP_PWR_CYC `VSP_CYC_UP(`VSP_T_PWR_US * 1000)

`endif

// File: rtl/vsp_pkg.sv
// types shared by the video memory serial port controller
// assumes nothing beyond a SystemVerilog compiler
package vsp_pkg;

	// ------------------------------------------------
	// commands and states
	// ------------------------------------------------
	typedef enum logic [2:0] {
		VSP_CMD_SRD = 3'h0, // single read transfer
		VSP_CMD_SWR = 3'h1, // single write transfer
		VSP_CMD_PRD = 3'h2, // split read transfer
		VSP_CMD_PWR = 3'h3, // split write transfer
		VSP_CMD_JMP = 3'h4 // refresh cycle that loads jump source
	} vsp_cmd_t;

	typedef enum logic [3:0] {
		VSP_ST_IDLE = 4'h0,
		VSP_ST_PWR = 4'h1,
		VSP_ST_DMY_L = 4'h3,
		VSP_ST_DMY_H = 4'h2,
		VSP_ST_SETUP = 4'h6,
		VSP_ST_RASL = 4'h7,
		VSP_ST_CASL = 4'h5,
		VSP_ST_RISE = 4'h4,
		VSP_ST_SCLO = 4'hc,
		VSP_ST_SCHI = 4'hd
	} vsp_state_t;

	// strobe and control pins toward the memory
	typedef struct packed {
		logic ras_n; // row strobe
		logic cas_n; // column strobe
		logic dtoe_n; // transfer_output_ctl_n
		logic uwe_n; // upper_write_n
		logic lwe_n; // lower_write_n
		logic special_function_sel; // special_function_sel
	} vsp_strobe_t;

endpackage

// File: rtl/vsp_sync.sv
// two flip-flop synchroniser for the pins coming back from the memory
// assumes inputs are asynchronous to clk; first stage read by second only
`timescale 1ns/100ps
module vsp_sync #(
	parameter int unsigned W = 17 // number of bits
) (
	input logic clk, // sampling clock
	input logic rst_n, // async reset, active low
	input logic ce, // clock enable
	input logic [W-1:0] d, // asynchronous inputs
	output logic [W-1:0] q // synchronised outputs
);
	logic [W-1:0] meta_q; // first stage, only feeds q

	// ------------------------------------------------
	// two stages
	// ------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			q <= '0;
		end else if (ce) begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule // vsp_sync

// File: rtl/vsp_ctrl.sv
// controller that drives the serial port of a dual-port video memory
// assumes an APB master on pclk and the memory's pins on the far side
`timescale 1ns/100ps
`include "vsp_consts.svh"
module vsp_ctrl #(
	parameter int unsigned PWR_CYC = `VSP_PWR_CYC, // power-up wait in cycles
	parameter int unsigned STB_CYC = `VSP_STB_CYC, // strobe phase in cycles
	parameter int unsigned SC_CYC = `VSP_SC_CYC // serial clock half period
) (
	input logic pclk, // system clock
	input logic presetn, // async reset, active low
	input logic ce, // clock enable, freezes all state
	input logic psel, // apb select
	input logic penable, // apb access phase
	input logic pwrite, // apb direction
	input logic [7:0] paddr, // apb byte address
	input logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error, unmapped address
	output vsp_pkg::vsp_strobe_t strobes, // strobe pins
	output logic [8:0] addr_pins, // multiplexed address
	output logic [15:0] mask_pins, // write mask data
	output logic serial_clock, // serial clock to memory
	output logic shift_port_gate_n, // serial enable, active low
	output logic [15:0] shift_data_o, // serial data out
	output logic shift_data_oe_n, // low while we drive serial data
	input logic [15:0] shift_data_i, // serial data in
	input logic half_indicator_out // half indicator from memory
);
	import vsp_pkg::*;

	localparam int unsigned PW = $clog2(PWR_CYC + 1); // power counter width
	localparam vsp_strobe_t STB_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};

	vsp_state_t state_q; // sequencer state
	logic [7:0] ph_q; // phase countdown
	logic [PW-1:0] pwr_q; // power-up wait counter
	logic [3:0] dmy_q; // dummy cycles done
	logic pwr_ok_q; // power-up sequence finished
	logic port_ready_q; // a single transfer has initialised the port
	logic mode_rd_q; // tracked serial direction, 1 = read
	logic refused_q; // sticky: a command was refused
	vsp_cmd_t cmd_q; // command in flight
	logic [8:0] row_q; // row address
	logic [8:0] col_q; // start column or jump source data
	logic [15:0] ser_wd_q; // word to shift out
	logic ser_gate_q; // 1 suppresses the serial access
	logic [15:0] rd_word_q; // last word read
	logic [16:0] sync_w; // synchronised {half, data}

	// ------------------------------------------------
	// helpers
	// ------------------------------------------------
	// phase length loaded on entry to a timed state
	function automatic logic [7:0] phase_len(input vsp_state_t s);
		if (s == VSP_ST_SCLO || s == VSP_ST_SCHI) begin
			phase_len = 8'(SC_CYC - 1);
		end else begin
			phase_len = 8'(STB_CYC - 1);
		end
	endfunction

	// a command is legal only in the right order
	function automatic logic cmd_legal(input vsp_cmd_t c, input logic rdy);
		unique case (c)
			VSP_CMD_SRD, VSP_CMD_SWR, VSP_CMD_JMP: cmd_legal = 1'b1;
			VSP_CMD_PRD, VSP_CMD_PWR: cmd_legal = rdy; // splits need an initialised port
			default: cmd_legal = 1'b0;
		endcase
	endfunction

	// ------------------------------------------------
	// pin synchroniser
	// ------------------------------------------------
	vsp_sync #(.W(17)) u_sync (
		.clk(pclk),
		.rst_n(presetn),
		.ce(ce),
		.d({half_indicator_out, shift_data_i}),
		.q(sync_w)
	);

	// ------------------------------------------------
	// apb decode
	// ------------------------------------------------
	logic acc_w; // access phase completing this edge
	logic wr_ctrl_w; // write to control with go set
	logic wr_ser_w; // write to the serial word register
	logic xfer_ok_w; // transfer command accepted
	logic ser_ok_w; // serial access accepted
	logic mapped_w; // address hits a register

	always_comb begin
		acc_w = psel && penable && pready;
		wr_ctrl_w = acc_w && pwrite && paddr == `VSP_OFF_CTRL && pwdata[`VSP_CTRL_GO];
		wr_ser_w = acc_w && pwrite && paddr == `VSP_OFF_SER;
		xfer_ok_w = wr_ctrl_w && state_q == VSP_ST_IDLE && pwr_ok_q
			&& cmd_legal(vsp_cmd_t'(pwdata[`VSP_CTRL_CMD_HI:`VSP_CTRL_CMD_LO]), port_ready_q);
		// no serial clock until a single transfer set the pointer
		ser_ok_w = wr_ser_w && state_q == VSP_ST_IDLE && port_ready_q;
		mapped_w = paddr == `VSP_OFF_CTRL || paddr == `VSP_OFF_ADDR
			|| paddr == `VSP_OFF_SER || paddr == `VSP_OFF_STAT;
	end

	// no wait state: answer is prepared during the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (ce) begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped_w;
			prdata <= 32'h0000_0000;
			if (psel && !penable && !pwrite) begin
				unique case (paddr)
					`VSP_OFF_CTRL: prdata <= {28'h0000000, 1'b0, cmd_q};
					`VSP_OFF_ADDR: prdata <= {7'h00, col_q, 7'h00, row_q};
					`VSP_OFF_SER: prdata <= {15'h0000, ser_gate_q, rd_word_q};
					`VSP_OFF_STAT: prdata <= {26'h0000000, refused_q, mode_rd_q,
						port_ready_q, pwr_ok_q, state_q != VSP_ST_IDLE, sync_w[16]};
					default: prdata <= 32'h0000_0000; // unmapped reads zero
				endcase
			end
		end
	end

	// ------------------------------------------------
	// software registers
	// ------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			row_q <= 9'h000;
			col_q <= 9'h000;
			ser_wd_q <= 16'h0000;
			ser_gate_q <= 1'b0;
			cmd_q <= VSP_CMD_SRD;
			refused_q <= 1'b0;
		end else if (ce) begin
			if (acc_w && pwrite && paddr == `VSP_OFF_ADDR) begin
				row_q <= pwdata[`VSP_ADDR_ROW_HI:`VSP_ADDR_ROW_LO];
				col_q <= pwdata[`VSP_ADDR_COL_HI:`VSP_ADDR_COL_LO];
			end
			if (ser_ok_w) begin
				ser_wd_q <= pwdata[15:0];
				ser_gate_q <= pwdata[`VSP_SER_GATE];
			end
			if (xfer_ok_w) begin
				cmd_q <= vsp_cmd_t'(pwdata[`VSP_CTRL_CMD_HI:`VSP_CTRL_CMD_LO]);
			end
			// refusal wins over a write-one clear in the same cycle
			if ((wr_ctrl_w && !xfer_ok_w) || (wr_ser_w && !ser_ok_w)) begin
				refused_q <= 1'b1;
			end else if (acc_w && pwrite && paddr == `VSP_OFF_STAT
				&& pwdata[`VSP_STAT_REFUSED]) begin
				refused_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------
	// sequencer and pins
	// ------------------------------------------------
	// the memory's own state is unknown after power, so nothing is assumed of it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= VSP_ST_PWR;
			ph_q <= 8'h00;
			pwr_q <= '0;
			dmy_q <= 4'h0;
			pwr_ok_q <= 1'b0;
			port_ready_q <= 1'b0;
			mode_rd_q <= 1'b0;
			rd_word_q <= 16'h0000;
			strobes <= STB_IDLE;
			addr_pins <= 9'h000;
			mask_pins <= 16'h0000;
			serial_clock <= 1'b0;
			shift_port_gate_n <= 1'b1;
			shift_data_o <= 16'h0000;
			shift_data_oe_n <= 1'b1;
		end else if (ce) begin
			if (ph_q != 8'h00) begin
				ph_q <= ph_q - 8'h01;
			end
			unique case (state_q)
				VSP_ST_PWR: begin
					pwr_q <= pwr_q + PW'(1);
					if (pwr_q == PW'(PWR_CYC - 1)) begin // full wait before any strobe
						state_q <= VSP_ST_DMY_L;
						strobes.ras_n <= 1'b0;
						ph_q <= phase_len(VSP_ST_DMY_L);
					end
				end
				VSP_ST_DMY_L: if (ph_q == 8'h00) begin
					state_q <= VSP_ST_DMY_H;
					strobes.ras_n <= 1'b1;
					ph_q <= phase_len(VSP_ST_DMY_H);
				end
				VSP_ST_DMY_H: if (ph_q == 8'h00) begin
					dmy_q <= dmy_q + 4'h1;
					if (dmy_q == 4'(`VSP_DUMMY_N - 1)) begin // eight dummy row cycles
						state_q <= VSP_ST_IDLE;
						pwr_ok_q <= 1'b1;
					end else begin
						state_q <= VSP_ST_DMY_L;
						strobes.ras_n <= 1'b0;
						ph_q <= phase_len(VSP_ST_DMY_L);
					end
				end
				VSP_ST_IDLE: begin
					if (xfer_ok_w) begin
						state_q <= VSP_ST_SETUP;
						ph_q <= phase_len(VSP_ST_SETUP);
						mask_pins <= 16'h0000; // no random-port cell is altered
						unique case (vsp_cmd_t'(pwdata[`VSP_CTRL_CMD_HI:`VSP_CTRL_CMD_LO]))
							VSP_CMD_SRD: begin
								strobes <= '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
								addr_pins <= row_q;
							end
							VSP_CMD_SWR: begin
								strobes <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
								addr_pins <= row_q;
							end
							VSP_CMD_PRD: begin
								strobes <= '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
								addr_pins <= row_q;
							end
							VSP_CMD_PWR: begin
								strobes <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
								addr_pins <= row_q;
							end
							default: begin
								// column before row refresh, writes low, jump data on A0..A7
								strobes <= '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
								addr_pins <= {1'b0, col_q[7:0]};
							end
						endcase
					end else if (ser_ok_w) begin
						state_q <= VSP_ST_SCLO;
						ph_q <= phase_len(VSP_ST_SCLO);
						shift_port_gate_n <= pwdata[`VSP_SER_GATE];
						shift_data_o <= pwdata[15:0];
						// drive only in write mode and only when gated in
						shift_data_oe_n <= mode_rd_q || pwdata[`VSP_SER_GATE];
					end
				end
				VSP_ST_SETUP: if (ph_q == 8'h00) begin
					state_q <= VSP_ST_RASL;
					strobes.ras_n <= 1'b0;
					ph_q <= phase_len(VSP_ST_RASL);
				end
				VSP_ST_RASL: if (ph_q == 8'h00) begin
					state_q <= VSP_ST_CASL;
					if (cmd_q != VSP_CMD_JMP) begin
						strobes.cas_n <= 1'b0; // start column always latched
					end
					ph_q <= phase_len(VSP_ST_CASL);
				end else if (cmd_q != VSP_CMD_JMP) begin
					// column goes out a cycle after the row fall, ahead of the column fall,
					// so the row is held past its strobe and the column is set up early
					addr_pins <= col_q;
				end
				VSP_ST_CASL: if (ph_q == 8'h00) begin
					state_q <= VSP_ST_RISE;
					strobes.ras_n <= 1'b1; // memory executes on this rise
					ph_q <= phase_len(VSP_ST_RISE);
				end
				VSP_ST_RISE: if (ph_q == 8'h00) begin
					state_q <= VSP_ST_IDLE;
					strobes <= STB_IDLE;
					if (cmd_q == VSP_CMD_SRD || cmd_q == VSP_CMD_SWR) begin
						port_ready_q <= 1'b1; // pointer now defined
						mode_rd_q <= cmd_q == VSP_CMD_SRD;
					end
				end
				VSP_ST_SCLO: if (ph_q == 8'h00) begin
					state_q <= VSP_ST_SCHI;
					serial_clock <= 1'b1;
					ph_q <= phase_len(VSP_ST_SCHI);
				end
				VSP_ST_SCHI: if (ph_q == 8'h00) begin
					state_q <= VSP_ST_IDLE;
					serial_clock <= 1'b0;
					shift_port_gate_n <= 1'b1;
					shift_data_oe_n <= 1'b1;
					if (mode_rd_q && !ser_gate_q) begin
						rd_word_q <= sync_w[15:0]; // word settled through the synchroniser
					end
				end
				default: begin
					state_q <= VSP_ST_IDLE;
					strobes <= STB_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------
	// checks
	// ------------------------------------------------
	AST_MASK_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(strobes.ras_n) && !strobes.dtoe_n && !strobes.uwe_n |-> mask_pins == 16'h0000)
		else $error("mask not zero at write transfer");
	AST_CAS_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(strobes.ras_n) && !strobes.dtoe_n && !strobes.uwe_n |-> $past(!strobes.cas_n))
		else $error("write transfer executed without column strobe");
	AST_SC_INIT: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(serial_clock) |-> port_ready_q)
		else $error("serial clock before single transfer");
	AST_SPLIT_INIT: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(strobes.ras_n) && strobes.special_function_sel |-> port_ready_q && !strobes.dtoe_n)
		else $error("split transfer before initialising transfer");
	AST_PWR_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(strobes.ras_n) |-> pwr_q == PW'(PWR_CYC))
		else $error("row strobe before power-up wait");
	AST_DUMMY_N: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(pwr_ok_q) |-> dmy_q == 4'(`VSP_DUMMY_N))
		else $error("wrong number of dummy cycles");
	AST_APB_WAIT: assert property (@(posedge pclk) disable iff (!presetn || !ce)
		psel && !penable ##1 psel && penable |-> pready)
		else $error("apb answer not in first access cycle");
endmodule // vsp_ctrl

// File: tb/vsp_mem_model.sv
// behavioural model of the memory's serial port, seen from its pins
// assumes the controller's strobe, address and serial pins; no reset pin exists
`timescale 1ns/100ps
module vsp_mem_model (
	input vsp_pkg::vsp_strobe_t strobes, // strobe pins
	input logic [8:0] addr_pins, // multiplexed address
	input logic [15:0] mask_pins, // write mask, unused by the model
	input logic serial_clock, // serial clock
	input logic shift_port_gate_n, // serial enable, active low
	input logic [15:0] shift_data_o, // serial data from controller
	input logic shift_data_oe_n, // controller drive, unused here
	output logic [15:0] shift_data_i, // serial data to controller
	output logic half_indicator_out // half indicator
);
	import vsp_pkg::*;
	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [15:0] sreg [512]; // serial register
	logic [8:0] ptr, tap, row; // pointer, start column, row
	logic [7:0] stop; // jump source data, undefined at power
	logic tap_full, mode_rd, xfer, split, wr_x; // transfer bookkeeping
	logic [15:0] last; // last word driven
	logic [7:0] jmask; // low column bits of a jump source
	int ras_falls; // row strobe falls since power
	// power-up: write mode, pins show the inverse of last; pointer left unknown
	initial begin
		mode_rd = 1'b0;
		tap_full = 1'b0;
		xfer = 1'b0;
		last = 16'h0000;
		ras_falls = 0;
	end
	assign jmask = {stop[7:4], 4'hf};
	assign half_indicator_out = ptr[8];
	// released pins show the inverse, never a stale value
	assign shift_data_i = (mode_rd && !shift_port_gate_n) ? last : ~last;
	// row strobe fall: decode the cycle, refresh loads jump source
	always @(negedge strobes.ras_n) begin
		ras_falls++;
		row = addr_pins;
		xfer = strobes.cas_n && !strobes.dtoe_n;
		split = strobes.special_function_sel;
		wr_x = !strobes.uwe_n && !strobes.lwe_n;
		if (!strobes.cas_n && wr_x) begin
			stop = addr_pins[7:0];
		end
	end
	// column strobe fall inside a transfer: start column
	always @(negedge strobes.cas_n) begin
		if (xfer && !strobes.ras_n) begin
			tap = split ? {~ptr[8], addr_pins[7:0]} : addr_pins;
		end
	end
	// row strobe rise executes the transfer
	always @(posedge strobes.ras_n) begin
		if (xfer) begin
			if (!wr_x) begin
				for (int i = 0; i < 512; i++) begin
					if (!split || i[8] != ptr[8]) sreg[i] = {row[6:0], i[8:0]};
				end
			end
			if (split) begin
				tap_full = 1'b1;
			end else begin
				ptr = tap;
				tap_full = 1'b0;
				mode_rd = !wr_x;
			end
			xfer = 1'b0;
		end
	end
	// serial clock rise: read, write or skip, then move the pointer
	always @(posedge serial_clock) begin
		if (mode_rd) begin
			last = sreg[ptr];
		end else if (!shift_port_gate_n) begin
			sreg[ptr] = shift_data_o;
		end
		if (tap_full && (ptr[7:0] & jmask) == jmask) begin
			ptr = tap;
			tap_full = 1'b0;
		end else begin
			ptr = ptr + 9'h001;
		end
	end
endmodule // vsp_mem_model

// File: tb/tb.sv
// self-checking bench of the serial port controller with a memory model
// assumes short power-up wait and strobe phases set by parameters
`timescale 1ns/100ps
`include "vsp_consts.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
	$display("BAD %s exp %h got %h", n, e, g); end end
module tb;
	import vsp_pkg::*;
	logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, serial_clock, shift_port_gate_n, shift_data_oe_n, half;
	vsp_strobe_t strobes;
	logic [8:0] addr_pins;
	logic [15:0] mask_pins, shift_data_o, shift_data_i;
	int bad_count = 0, comparisons = 0;
	always #4 pclk = ~pclk;
	vsp_ctrl #(.PWR_CYC(20), .STB_CYC(5), .SC_CYC(3)) u_dut (.pclk(pclk), .presetn(presetn),
		.ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.strobes(strobes), .addr_pins(addr_pins), .mask_pins(mask_pins),
		.serial_clock(serial_clock), .shift_port_gate_n(shift_port_gate_n),
		.shift_data_o(shift_data_o), .shift_data_oe_n(shift_data_oe_n),
		.shift_data_i(shift_data_i), .half_indicator_out(half));
	vsp_mem_model u_mem (.strobes(strobes), .addr_pins(addr_pins), .mask_pins(mask_pins),
		.serial_clock(serial_clock), .shift_port_gate_n(shift_port_gate_n),
		.shift_data_o(shift_data_o), .shift_data_oe_n(shift_data_oe_n),
		.shift_data_i(shift_data_i), .half_indicator_out(half));
	// mask must be zero at every row strobe fall
	always @(negedge strobes.ras_n) `CHK("mask", 16'h0000, mask_pins)
	// ----------------------------------------
	// bus tasks
	// ----------------------------------------
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		if (n >= 100) bad_count++;
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk); // one edge apart, never two drives in a step
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		logic e;
		apb(1'b0, a, 32'h0, q, e);
	endtask
	// poll until not busy, bounded
	task automatic idle_wait();
		logic [31:0] s;
		int n;
		n = 0;
		do begin
			rd(`VSP_OFF_STAT, s);
			n++;
		end while (s[`VSP_STAT_BUSY] !== 1'b0 && n < 60);
		if (n >= 60) bad_count++;
	endtask
	task automatic xfer(input logic [2:0] c, input logic [8:0] r, input logic [8:0] col);
		wr(`VSP_OFF_ADDR, {7'h00, col, 7'h00, r});
		wr(`VSP_OFF_CTRL, {28'h0, c, 1'b1});
		idle_wait();
	endtask
	task automatic ser(input logic g, input logic [15:0] w, output logic [31:0] q);
		wr(`VSP_OFF_SER, {15'h0, g, w});
		idle_wait();
		rd(`VSP_OFF_SER, q);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_power();
		logic [31:0] s;
		logic e;
		int n;
		wr(`VSP_OFF_CTRL, 32'h1); // too early, refused
		rd(`VSP_OFF_STAT, s);
		`CHK("early refused", 1'b1, s[5])
		n = 0;
		do begin
			rd(`VSP_OFF_STAT, s);
			n++;
		end while (s[2] !== 1'b1 && n < 200);
		if (n >= 200) bad_count++;
		`CHK("dummies", 8, u_mem.ras_falls)
		`CHK("power mode", 1'b0, s[4])
		`CHK("power float", 1'b1, shift_data_oe_n)
		wr(`VSP_OFF_STAT, 32'h20);
		rd(`VSP_OFF_STAT, s);
		`CHK("refused clear", 1'b0, s[5])
		wr(`VSP_OFF_CTRL, {28'h0, 3'h2, 1'b1}); // split before any single
		rd(`VSP_OFF_STAT, s);
		`CHK("split early", 1'b1, s[5])
		wr(`VSP_OFF_STAT, 32'h20);
		wr(`VSP_OFF_SER, 32'h0); // serial clock before any single
		rd(`VSP_OFF_STAT, s);
		`CHK("clock early", 1'b1, s[5])
		wr(`VSP_OFF_STAT, 32'h20);
		apb(1'b0, 8'h10, 32'h0, s, e);
		`CHK("unmapped", 1'b1, e)
		$display("done power");
	endtask
	task automatic t_read();
		logic [31:0] s;
		xfer(3'h0, 9'h005, 9'h00a);
		rd(`VSP_OFF_STAT, s);
		`CHK("read mode", 1'b1, s[4])
		`CHK("start col", 9'h00a, u_mem.ptr)
		ser(1'b0, 16'h0, s);
		`CHK("read word", 16'h0a0a, s[15:0])
		ser(1'b1, 16'h0, s);
		ser(1'b0, 16'h0, s);
		`CHK("skip word", 16'h0a0c, s[15:0])
		xfer(3'h3, 9'h005, 9'h020);
		rd(`VSP_OFF_STAT, s);
		`CHK("split wr keeps", 1'b1, s[4])
		$display("done read");
	endtask
	task automatic t_write();
		logic [31:0] s;
		logic [15:0] old;
		xfer(3'h1, 9'h003, 9'h014);
		rd(`VSP_OFF_STAT, s);
		`CHK("write mode", 1'b0, s[4])
		old = u_mem.sreg[21];
		ser(1'b0, 16'hbeef, s);
		ser(1'b1, 16'h1234, s);
		ser(1'b0, 16'hcafe, s);
		`CHK("wr 20", 16'hbeef, u_mem.sreg[20])
		`CHK("wr 21 kept", old, u_mem.sreg[21])
		`CHK("wr 22", 16'hcafe, u_mem.sreg[22])
		xfer(3'h2, 9'h003, 9'h000);
		rd(`VSP_OFF_STAT, s);
		`CHK("split rd keeps", 1'b0, s[4])
		$display("done write");
	endtask
	task automatic t_jump();
		logic [31:0] s;
		xfer(3'h4, 9'h000, 9'h00f);
		`CHK("jump src", 8'h0f, u_mem.stop)
		xfer(3'h0, 9'h007, 9'h00e);
		ser(1'b0, 16'h0, s);
		ser(1'b0, 16'h0, s);
		`CHK("no jump empty", 9'h010, u_mem.ptr)
		xfer(3'h2, 9'h007, 9'h005);
		for (int i = 0; i < 15; i++) ser(1'b1, 16'h0, s);
		ser(1'b0, 16'h0, s);
		`CHK("col 31", 16'h0e1f, s[15:0])
		ser(1'b0, 16'h0, s);
		`CHK("jumped", 16'h0f05, s[15:0])
		rd(`VSP_OFF_STAT, s);
		`CHK("upper half", 1'b1, s[0])
		$display("done jump");
	endtask
	task automatic t_wrap();
		logic [31:0] s;
		vsp_strobe_t hold;
		wr(`VSP_OFF_ADDR, {7'h00, 9'h1fe, 7'h00, 9'h002});
		wr(`VSP_OFF_CTRL, {28'h0, 3'h0, 1'b1});
		// freeze the transfer in flight: no strobe may move while enable is low
		ce <= 1'b0;
		@(posedge pclk);
		hold = strobes;
		repeat (8) @(posedge pclk);
		`CHK("ce freeze", hold, strobes)
		ce <= 1'b1;
		idle_wait();
		ser(1'b0, 16'h0, s);
		ser(1'b0, 16'h0, s);
		`CHK("col 511", 16'h05ff, s[15:0])
		rd(`VSP_OFF_STAT, s);
		`CHK("lower half", 1'b0, s[0])
		ser(1'b0, 16'h0, s);
		`CHK("wrap 0", 16'h0400, s[15:0])
		wr(`VSP_OFF_CTRL, {28'h0, 3'h5, 1'b1}); // unknown command
		rd(`VSP_OFF_STAT, s);
		`CHK("bad cmd", 1'b1, s[5])
		$display("done wrap");
	endtask
	task automatic results();
		$display("comparisons %0d bad_count %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_power();
		t_read();
		t_write();
		t_jump();
		t_wrap();
		results();
	end
	// watchdog, far beyond the expected run
	initial begin
		repeat (60000) @(posedge pclk);
		bad_count++;
		results();
	end
endmodule // tb
